// ==== hdl/res_sequencer.sv ====
// Enable, soft-start, fault-retry and register bank of the regulator
`timescale 1ns/100ps
module res_sequencer #(
  parameter logic [7:0] OPTION      = res_pkg::OPT_00,
  parameter longint     RETRY_CYC   = res_pkg::RETRY_CYCLES,
  parameter int         SS_STEPS    = res_pkg::SS_STEPS_DEF
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_hw_enable,
  input  wire logic                      i_voltage_select_pin,
  input  wire logic                      i_cycle_end,
  input  wire logic                      i_cycle_ilim,
  input  wire res_pkg::res_wreq_t        i_wreq,
  input  wire logic                      i_rd,
  output res_pkg::res_regs_t             o_rdata,
  output logic                           o_rd_valid,
  output logic                           o_access_refused,
  output logic                           o_circuits_on,
  output logic                           o_output_on,
  output logic                           o_switch_enable,
  output logic                           o_switch_hiz,
  output logic                           o_sync_rect_en,
  output logic [res_pkg::SS_W-1:0]       o_ref_ramp,
  output logic                           o_soft_start,
  output logic                           o_discharge,
  output logic                           o_pulse_skip_light_load,
  output logic [res_pkg::VOLTAGE_SELECT_PIN_W-1:0]     o_vout_code,
  output logic [2:0]                     o_state
);

  // ==========================================================
  // Option decoding
  // ==========================================================
  function automatic logic opt_is(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  localparam logic OPT_LOSE_REGS = opt_is(OPTION, res_pkg::OPT_04) ||
                                   opt_is(OPTION, res_pkg::OPT_24) ||
                                   opt_is(OPTION, res_pkg::OPT_042);
  localparam logic OPT_EN_10     = opt_is(OPTION, res_pkg::OPT_01) ||
                                   opt_is(OPTION, res_pkg::OPT_05);
  localparam logic OPT_SEL_LOW   = opt_is(OPTION, res_pkg::OPT_03);

  // Defaults built once so power-on and enable-low reload agree
  localparam res_pkg::res_regs_t REG_DEF = '{
    set0:           '{force_pwm: 1'b0, code: res_pkg::VSET0_DEF},
    set1:           '{force_pwm: 1'b0, code: res_pkg::VSET1_DEF},
    sw_enable_set0: 1'b1,
    sw_enable_set1: OPT_EN_10 ? 1'b0 : 1'b1,
    discharge_en:   1'b0
  };

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic en_s1_r, en_s2_r, en_d_r;
  logic sel_s1_r, sel_s2_r;

  // Enable pin; the third flop only feeds the rise detector
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      en_d_r  <= 1'b0;
    end else begin
      en_s1_r <= i_hw_enable;
      en_s2_r <= en_s1_r;
      en_d_r  <= en_s2_r;
    end
  end

  // Select pin is a level, so no edge detector is kept for it
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
    end else begin
      sel_s1_r <= i_voltage_select_pin;
      sel_s2_r <= sel_s1_r;
    end
  end

  logic en_pin, sel_eff, en_rise;
  assign en_pin  = en_s2_r;
  assign sel_eff = OPT_SEL_LOW ? 1'b0 : sel_s2_r;
  assign en_rise = en_s2_r && !en_d_r;

  // ==========================================================
  // Register bank
  // ==========================================================
  res_pkg::res_regs_t regs_r;

  // Reset is treated as power-on; regs keep through enable low except options 04, 24, 042
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      regs_r <= REG_DEF;
    end else if (!en_pin) begin
      if (OPT_LOSE_REGS) begin
        regs_r <= REG_DEF;
      end else begin
        regs_r <= regs_r;
      end
    end else if (i_wreq.wr) begin
      regs_r <= i_wreq.data;
    end
  end

  logic rd_take;
  assign rd_take = i_rd && en_pin;

  // Reads answer one cycle later and only while the pin is high
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_rdata    <= '0;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= rd_take;
      if (rd_take) begin
        o_rdata <= regs_r;
      end
    end
  end

  // Any access with the pin low is refused and flagged
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_access_refused <= 1'b0;
    end else begin
      o_access_refused <= (i_rd || i_wreq.wr) && !en_pin;
    end
  end

  // ==========================================================
  // Enable decision
  // ==========================================================
  logic       sel_bit;
  res_pkg::res_vset_t act_set;
  assign sel_bit = sel_eff ? regs_r.sw_enable_set1
                           : regs_r.sw_enable_set0;
  assign act_set = sel_eff ? regs_r.set1 : regs_r.set0;

  logic want_on;
  assign want_on = en_pin && sel_bit;

  // ==========================================================
  // Sequencer
  // ==========================================================
  res_pkg::res_state_t state_r, state_nxt;
  logic [res_pkg::SS_W-1:0] ramp_r;
  logic [4:0]               ilim_cnt_r;
  logic                     ilim_trip;
  logic                     retry_done;
  logic                     ss_done;

  assign ss_done   = (ramp_r == res_pkg::SS_W'(SS_STEPS - 1));
  assign ilim_trip = i_cycle_end && i_cycle_ilim &&
                     (ilim_cnt_r == 5'(res_pkg::ILIM_RUN - 1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      res_pkg::RES_OFF: begin
        // Software enable turning on with pin high also starts up
        if (want_on && (en_rise || state_r == res_pkg::RES_OFF)) begin
          state_nxt = res_pkg::RES_SOFT;
        end
      end
      res_pkg::RES_SOFT: begin
        if (!want_on) begin
          state_nxt = res_pkg::RES_OFF;
        end else if (ilim_trip) begin
          state_nxt = res_pkg::RES_FAULT;
        end else if (ss_done) begin
          state_nxt = res_pkg::RES_RUN;
        end
      end
      res_pkg::RES_RUN: begin
        if (!want_on) begin
          state_nxt = res_pkg::RES_OFF;
        end else if (ilim_trip) begin
          state_nxt = res_pkg::RES_FAULT;
        end
      end
      res_pkg::RES_FAULT: begin
        if (!want_on) begin
          state_nxt = res_pkg::RES_OFF;
        end else if (retry_done) begin
          state_nxt = res_pkg::RES_SOFT;
        end
      end
      default: state_nxt = res_pkg::RES_OFF;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state_r <= res_pkg::RES_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reference ramp restarts at zero on every entry to soft-start
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ramp_r <= '0;
    end else if (state_r != res_pkg::RES_SOFT) begin
      ramp_r <= '0;
    end else if (!ss_done) begin
      ramp_r <= ramp_r + res_pkg::SS_W'(1);
    end
  end

  // Consecutive current-limit cycle count
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ilim_cnt_r <= '0;
    end else if (state_r != res_pkg::RES_SOFT &&
                 state_r != res_pkg::RES_RUN) begin
      ilim_cnt_r <= '0;
    end else if (i_cycle_end) begin
      if (!i_cycle_ilim || ilim_trip) begin
        ilim_cnt_r <= '0;
      end else begin
        ilim_cnt_r <= ilim_cnt_r + 5'h1;
      end
    end
  end

  res_retry_timer #(
    .CYCLES (RETRY_CYC)
  ) u_retry (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (ilim_trip && state_nxt == res_pkg::RES_FAULT),
    .i_abort    (state_r != res_pkg::RES_FAULT &&
                 state_nxt != res_pkg::RES_FAULT),
    .o_done     (retry_done)
  );

  // ==========================================================
  // Outputs, registered
  // ==========================================================
  // Switching stage is live in soft-start and run only
  function automatic logic stage_live(input res_pkg::res_state_t s);
    return (s == res_pkg::RES_SOFT) || (s == res_pkg::RES_RUN);
  endfunction

  // Power stage follows the next state so it moves with the decision
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_circuits_on   <= 1'b0;
      o_output_on     <= 1'b0;
      o_switch_enable <= 1'b0;
      o_switch_hiz    <= 1'b1;
    end else begin
      o_circuits_on   <= en_pin;
      o_output_on     <= stage_live(state_nxt);
      o_switch_enable <= stage_live(state_nxt);
      // Float in shutdown and fault so a pre-charged load is not pulled
      o_switch_hiz    <= !stage_live(state_nxt);
    end
  end

  // Rectifier held off until the ramp is through
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_sync_rect_en <= 1'b0;
      o_soft_start   <= 1'b0;
      o_ref_ramp     <= '0;
    end else begin
      o_sync_rect_en <= (state_nxt == res_pkg::RES_RUN);
      o_soft_start   <= (state_nxt == res_pkg::RES_SOFT);
      o_ref_ramp     <= ramp_r;
    end
  end

  // Bleed load while the bit is set and the stage is not asked on
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_discharge <= 1'b0;
    end else begin
      o_discharge <= regs_r.discharge_en &&
                     (!en_pin || !sel_bit);
    end
  end

  // Active voltage setting, picked by the effective select
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_pulse_skip_light_load <= 1'b0;
      o_vout_code             <= '0;
    end else begin
      o_pulse_skip_light_load <= !act_set.force_pwm;
      o_vout_code             <= act_set.code;
    end
  end

  // State mirror, one cycle behind the sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_state <= 3'h0;
    end else begin
      o_state <= state_r;
    end
  end

endmodule

// ==== hdl/res_pkg.sv ====
// Package of constants and types for the regulator enable sequencer
// How it works
// - Enable pin low: shut down and refuse every register read and write.
// - Other options keep every register value while the enable pin is low.
// - Options 04, 24, 042 reload register defaults while the pin is low.
// - Power-on reset loads every register with its default value.
// - Discharge bit high with pin or active enable bit low: bleed output; options 04, 24, 042 reload it low once the pin is low.
// - Enable pin rising with selected enable bit high starts soft-start.
// - Soft-start ramps the reference and inhibits synchronous rectification.
// - Sixteen current-limit cycles: shut down, float switch, retry later.
// - Software enable bits only act while the enable pin is high.
// - Options 00,04,08,09,23,24,042 reset both software enables high.
// - Options 01 and 05 reset enables to set0 high, set1 low.
// - Option 03 treats the voltage select input as always low.
// - Output on only with pin high and the selected enable bit high.
// - Mode bit high disables light-load pulse skipping, forces fixed PWM.
// - Select low picks set-0 voltage register, high picks set-1.
package res_pkg;

  // Option codes, decimal as printed on the option list
  localparam logic [7:0] OPT_00  = 8'h00;
  localparam logic [7:0] OPT_01  = 8'h01;
  localparam logic [7:0] OPT_03  = 8'h03;
  localparam logic [7:0] OPT_04  = 8'h04;
  localparam logic [7:0] OPT_05  = 8'h05;
  localparam logic [7:0] OPT_08  = 8'h08;
  localparam logic [7:0] OPT_09  = 8'h09;
  localparam logic [7:0] OPT_23  = 8'h17;
  localparam logic [7:0] OPT_24  = 8'h18;
  localparam logic [7:0] OPT_042 = 8'h2A;

  localparam int          CLK_PERIOD_PS  = 5000;
  localparam longint      RETRY_WAIT_MS  = 1700;
  localparam longint      RETRY_CYCLES   =
    (RETRY_WAIT_MS * 64'd1000000000) / CLK_PERIOD_PS;
  localparam int          ILIM_RUN       = 16;
  localparam int          SS_STEPS_DEF   = 64;
  localparam int          VOLTAGE_SELECT_PIN_W         = 6;
  localparam int          SS_W           = 8;

  // Register bank defaults
  localparam logic [VOLTAGE_SELECT_PIN_W-1:0] VSET0_DEF = 6'h2D;
  localparam logic [VOLTAGE_SELECT_PIN_W-1:0] VSET1_DEF = 6'h3C;

  typedef enum logic [2:0] {
    RES_OFF, RES_SOFT, RES_RUN, RES_FAULT
  } res_state_t;

  // One voltage setting register: code and mode bit
  typedef struct packed {
    logic              force_pwm;
    logic [VOLTAGE_SELECT_PIN_W-1:0] code;
  } res_vset_t;

  // Software-visible register bank
  typedef struct packed {
    res_vset_t set0;
    res_vset_t set1;
    logic      sw_enable_set0;
    logic      sw_enable_set1;
    logic      discharge_en;
  } res_regs_t;

  // Serial-bus side register write request
  typedef struct packed {
    logic      wr;
    res_regs_t data;
  } res_wreq_t;

endpackage

// ==== hdl/res_retry_timer.sv ====
// Cycle counter that times the fault retry wait
`timescale 1ns/100ps
module res_retry_timer #(
  parameter longint CYCLES = 64'd1
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_start,
  input  wire logic i_abort,
  output logic      o_done
);
  logic [39:0] cnt_r;
  logic        busy_r;

  // Done is a pulse on the last cycle of the wait
  assign o_done = busy_r && (cnt_r == 40'h0);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || i_abort) begin
      busy_r <= 1'b0;
      cnt_r  <= 40'h0;
    end else if (i_start) begin
      busy_r <= 1'b1;
      cnt_r  <= 40'(CYCLES - 64'd1);
    end else if (busy_r) begin
      if (cnt_r == 40'h0) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 40'h1;
      end
    end
  end
endmodule

// ==== verification/res_sequencer_asserts.sv ====
// Checker for the regulator enable sequencer, bound to every instance
`timescale 1ns/100ps
module res_sequencer_asserts #(
  parameter longint RETRY_CYC = 1
) (
  input wire logic                    i_core_clk,
  input wire logic                    i_reset_n,
  input wire logic                    i_hw_enable,
  input wire logic                    i_rd,
  input wire logic                    i_cycle_end,
  input wire logic                    i_cycle_ilim,
  input wire logic                    o_rd_valid,
  input wire logic                    o_access_refused,
  input wire logic                    o_output_on,
  input wire logic                    o_switch_enable,
  input wire logic                    o_switch_hiz,
  input wire logic                    o_sync_rect_en,
  input wire logic [res_pkg::SS_W-1:0] o_ref_ramp,
  input wire logic                    o_soft_start,
  input wire logic [2:0]              o_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // ==============================
  // Helper counters
  int lim_cnt;
  int flt_cnt;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || !o_switch_enable) lim_cnt <= 0;
    else if (i_cycle_end) lim_cnt <= i_cycle_ilim ? lim_cnt + 1 : 0;
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || o_state != 3'h3) flt_cnt <= 0;
    else flt_cnt <= flt_cnt + 1;
  end
  // ==============================
  // Properties
  // Pin history spans the two-flop synchroniser
  sequence s_pin_low; !i_hw_enable [*4]; endsequence
  sequence s_pin_high; i_hw_enable [*4]; endsequence
  property p_refuse;
    s_pin_low ##0 i_rd |=> o_access_refused && !o_rd_valid;
  endproperty
  property p_accept;
    s_pin_high ##0 i_rd |=> o_rd_valid && !o_access_refused;
  endproperty
  property p_off;
    !i_hw_enable [*6] |-> !o_output_on && o_switch_hiz;
  endproperty
  property p_ss; o_soft_start |-> !o_sync_rect_en && !o_switch_hiz; endproperty
  // The ramp output trails the soft-start flag by one cycle
  property p_ramp;
    o_soft_start && $past(o_soft_start) && $past(o_soft_start, 2)
      |-> o_ref_ramp > $past(o_ref_ramp);
  endproperty
  property p_run;
    o_state == 3'h2 |-> $past(o_sync_rect_en) && !$past(o_switch_hiz);
  endproperty
  property p_fault;
    lim_cnt == 15 && i_cycle_end && i_cycle_ilim |-> ##[1:6] o_state == 3'h3;
  endproperty
  // State mirror lags the stage outputs by one cycle
  property p_hiz;
    o_state == 3'h3 && $past(o_state) == 3'h3
      |-> $past(o_switch_hiz) && !$past(o_output_on);
  endproperty
  property p_wait; o_state == 3'h3 |-> flt_cnt <= RETRY_CYC + 3; endproperty
  property p_retry;
    $past(o_state) == 3'h3 && o_state != 3'h3 && i_hw_enable
      |-> o_state == 3'h1 && $past(flt_cnt) >= RETRY_CYC - 3;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("access not refused with pin low");
  a_accept: assert property (p_accept)
    else $error("read not answered with pin high");
  a_off: assert property (p_off)
    else $error("output on with pin low");
  a_ss: assert property (p_ss)
    else $error("rectifier on during soft start");
  a_ramp: assert property (p_ramp)
    else $error("reference ramp not rising");
  a_run: assert property (p_run)
    else $error("rectifier off in run");
  a_fault: assert property (p_fault)
    else $error("no shutdown after limit run");
  a_hiz: assert property (p_hiz)
    else $error("switch not floating in fault");
  a_wait: assert property (p_wait)
    else $error("fault wait too long");
  a_retry: assert property (p_retry)
    else $error("retry early or not into soft start");
endmodule

bind res_sequencer res_sequencer_asserts #(.RETRY_CYC(RETRY_CYC)) u_chk (
  .i_core_clk, .i_reset_n, .i_hw_enable, .i_rd, .i_cycle_end, .i_cycle_ilim,
  .o_rd_valid, .o_access_refused, .o_output_on, .o_switch_enable,
  .o_switch_hiz, .o_sync_rect_en, .o_ref_ramp, .o_soft_start, .o_state);

// ==== verification/res_host.sv ====
// Host model driving the enable pins and the register requests
`timescale 1ns/100ps
module res_host (
  input  wire logic          i_core_clk,
  output logic               o_hw_enable,
  output logic               o_voltage_select_pin,
  output res_pkg::res_wreq_t o_wreq,
  output logic               o_rd
);
  // Select starts low: a host fed by this rail must boot on set 0
  initial begin
    o_hw_enable = 1'b1;
    o_voltage_select_pin = 1'b0;
    o_wreq = '0;
    o_rd = 1'b0;
  end
  task pins(input logic en, input logic sel);
    @(posedge i_core_clk);
    o_hw_enable <= en;
    o_voltage_select_pin <= sel;
  endtask
  // Data is inverted after release so stale values never look valid
  task access(input logic rd, input res_pkg::res_regs_t d);
    @(posedge i_core_clk);
    o_rd <= rd;
    o_wreq <= '{wr: !rd, data: d};
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_wreq <= '{wr: 1'b0, data: ~d};
  endtask
endmodule

// ==== verification/tb_res_sequencer.sv ====
// Self-checking bench for the regulator enable sequencer
`timescale 1ns/100ps
module tb_res_sequencer;
  // ==============================
  // Signals, three option variants
  localparam logic [7:0] opts [3] =
    '{res_pkg::OPT_01, res_pkg::OPT_03, res_pkg::OPT_04};
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               ce = 1'b0;
  logic               il = 1'b0;
  logic               en;
  logic               sel;
  logic               rd;
  logic [31:0]        rnd;
  res_pkg::res_wreq_t wq;
  res_pkg::res_regs_t w;
  res_pkg::res_regs_t rdat [3];
  logic               rv [3];
  logic               rf [3];
  logic               on [3];
  logic               hz [3];
  logic               co [3];
  logic               dis [3];
  logic               pk [3];
  logic [5:0]         vc [3];
  logic [2:0]         st [3];
  int                 err_total = 0;
  int                 samples_checked = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  res_host u_host (.i_core_clk(clk), .o_hw_enable(en),
    .o_voltage_select_pin(sel), .o_wreq(wq), .o_rd(rd));
  for (genvar g = 0; g < 3; g++) begin : gen_dut
    res_sequencer #(.OPTION(opts[g]), .RETRY_CYC(20), .SS_STEPS(8)) u_dut (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_hw_enable(en),
      .i_voltage_select_pin(sel), .i_cycle_end(ce), .i_cycle_ilim(il),
      .i_wreq(wq), .i_rd(rd), .o_rdata(rdat[g]), .o_rd_valid(rv[g]),
      .o_access_refused(rf[g]), .o_circuits_on(co[g]), .o_output_on(on[g]),
      .o_switch_enable(), .o_switch_hiz(hz[g]), .o_sync_rect_en(),
      .o_ref_ramp(), .o_soft_start(), .o_discharge(dis[g]),
      .o_pulse_skip_light_load(pk[g]), .o_vout_code(vc[g]), .o_state(st[g]));
  end
  // ==============================
  // Tasks
  function automatic res_pkg::res_regs_t dflt(input int g);
    dflt = '0;
    dflt.set0.code = res_pkg::VSET0_DEF;
    dflt.set1.code = res_pkg::VSET1_DEF;
    dflt.sw_enable_set0 = 1'b1;
    dflt.sw_enable_set1 = (g == 2);
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %0h got %0h", n, e, s);
    end
  endtask
  task close_out();
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wait_st(input int g, input logic [2:0] s);
    for (int n = 0; n < 200 && st[g] !== s; n++) @(negedge clk);
    if (st[g] !== s) begin
      chk("state", s, st[g]);
      close_out();
    end
  endtask
  task rd_bank(input logic ok);
    u_host.access(1'b1, '0);
    repeat (4) begin
      @(negedge clk);
      if (rv[0] === 1'b1 || rf[0] === 1'b1) break;
    end
    for (int g = 0; g < 3; g++) begin
      chk("rd_valid", ok, rv[g]);
      chk("refused", !ok, rf[g]);
    end
    if (rv[0] !== 1'b1 && rf[0] !== 1'b1) close_out();
  endtask
  // Enable bits of the option without a stated default are masked
  task bank(input int g, input res_pkg::res_regs_t e, input logic m);
    res_pkg::res_regs_t r;
    r = rdat[g];
    if (m) begin
      r.sw_enable_set0 = e.sw_enable_set0;
      r.sw_enable_set1 = e.sw_enable_set1;
    end
    chk("bank", e, r);
  endtask
  task cyc(input int n, input logic lim);
    repeat (n) begin
      @(posedge clk);
      ce <= 1'b1;
      il <= lim;
      @(posedge clk);
      ce <= 1'b0;
    end
  endtask
  // ==============================
  // Main sequence
  initial begin
    void'($urandom(30562));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_bank(1'b1);
    for (int g = 0; g < 3; g++) begin
      bank(g, dflt(g), g == 1);
    end
    wait_st(0, 3'h2);
    wait_st(2, 3'h2);
    for (int g = 0; g < 3; g++) begin
      chk("vout", res_pkg::VSET0_DEF, vc[g]);
    end
    u_host.pins(1'b1, 1'b1);
    repeat (8) @(negedge clk);
    chk("on", 0, on[0]);
    chk("on", 1, on[1]);
    chk("vout", res_pkg::VSET0_DEF, vc[1]);
    chk("vout", res_pkg::VSET1_DEF, vc[2]);
    rnd = $urandom;
    w = rnd[$bits(w)-1:0];
    w.sw_enable_set0 = 1'b1;
    w.sw_enable_set1 = 1'b0;
    w.discharge_en = 1'b1;
    u_host.access(1'b0, w);
    repeat (8) @(negedge clk);
    for (int g = 0; g < 3; g++) begin
      chk("dis", g != 1, dis[g]);
      chk("on", g == 1, on[g]);
      chk("pfm", g == 1 ? !w.set0.force_pwm : !w.set1.force_pwm,
          pk[g]);
      chk("circ", 1, co[g]);
    end
    rd_bank(1'b1);
    for (int g = 0; g < 3; g++) bank(g, w, 1'b0);
    u_host.pins(1'b0, 1'b1);
    repeat (8) @(negedge clk);
    rd_bank(1'b0);
    for (int g = 0; g < 3; g++) begin
      chk("on", 0, on[g]);
      chk("circ", 0, co[g]);
      chk("dis", g != 2, dis[g]);
    end
    u_host.pins(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    rd_bank(1'b1);
    for (int g = 0; g < 3; g++) begin
      bank(g, g == 2 ? dflt(2) : w, 1'b0);
    end
    wait_st(2, 3'h2);
    cyc(15, 1'b1);
    cyc(1, 1'b0);
    cyc(15, 1'b1);
    repeat (3) @(negedge clk);
    chk("state", 2, st[2]);
    cyc(1, 1'b0);
    cyc(16, 1'b1);
    repeat (6) @(negedge clk);
    chk("state", 3, st[2]);
    chk("hiz", 1, hz[2]);
    wait_st(2, 3'h1);
    wait_st(2, 3'h2);
    repeat (20) begin
      cyc($urandom_range(15, 1), 1'b1);
      cyc(1, 1'b0);
    end
    repeat (3) @(negedge clk);
    chk("state", 2, st[2]);
    close_out();
  end
endmodule
